// ===== src/eep_pkg.sv
// constants for the parallel eeprom host controller
// assumes a 125 MHz clock and a classic wishbone register port
package eep_pkg;
    localparam int CLK_NS = 8;
    // pin timing, each time rounded up to whole cycles
    localparam int T_SU_NS = 10;
    localparam int SU_CYC = (T_SU_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_WP_NS = 100;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_ACC_NS = 150;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_HOLD_NS = 10;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PUR_US = 1;
    localparam int PUR_CYC = (PUR_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PUW_MS = 10;
    localparam int ERASE_MS = 10;
    localparam int PAGE_WIN_US = 150;
    localparam int MS_CYC = 1000000 / CLK_NS;
    localparam int CNT_W = 21;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    // status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_PAGE_MIX = 2;
    localparam int ST_WIN_OPEN = 3;
    localparam int ST_WRITE_OK = 4;
    localparam int ST_READ_OK = 5;
    localparam int ST_READY = 6;
    localparam int ST_RDATA = 8;
    localparam int TOGGLE_BIT = 6;
    localparam int PAGE_LSB = 6;
    localparam int ADDR_W = 11;
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE, OP_POLL} eep_op_t;
endpackage

// ===== src/eep_seq_if.sv
// request and answer between the controller and its pin sequencer
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface eep_seq_if;
    logic req;
    eep_pkg::eep_op_t op;
    logic [10:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport ctl (output req, op, addr, wdata, input done, rdata);
    modport seq (input req, op, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ===== src/eep_pin_seq.sv
// pin sequencer: one read, byte write or chip erase cycle per request
// assumes req only while idle; erase needs a high voltage driver on oe
`timescale 1ns/1ns
`default_nettype none
module eep_pin_seq #(
    parameter int ERASE_CYC = 1250000
) (
    input wire logic i_clk,
    input wire logic i_rst,
    eep_seq_if.seq sif,
    output logic [10:0] o_addr,
    output logic [7:0] o_dq,
    output logic o_dq_oe,
    input wire logic [7:0] i_dq,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_oe_hv
);
    typedef enum {S_IDLE, S_SETUP, S_PULSE, S_HOLD} eep_seq_st_t;
    eep_seq_st_t st_q, st_d;
    logic [eep_pkg::CNT_W-1:0] cnt_q, cnt_d;
    eep_pkg::eep_op_t op_q, op_d;
    logic [10:0] addr_q, addr_d;
    logic [7:0] dq_q, dq_d, rd_q, rd_d;
    logic dq_oe_q, dq_oe_d, ce_q, ce_d, oe_q, oe_d, we_q, we_d;
    logic hv_q, hv_d, done_q, done_d;

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        op_d = op_q;
        addr_d = addr_q;
        dq_d = dq_q;
        rd_d = rd_q;
        dq_oe_d = dq_oe_q;
        ce_d = ce_q;
        oe_d = oe_q;
        we_d = we_q;
        hv_d = hv_q;
        done_d = 1'b0;
        if (cnt_q != '0)
        begin
            cnt_d = cnt_q - 1'b1;
        end
        unique case (st_q)
            S_IDLE:
            begin
                if (sif.req)
                begin
                    op_d = sif.op;
                    addr_d = sif.addr;
                    dq_d = sif.wdata;
                    ce_d = 1'b0;
                    hv_d = (sif.op == eep_pkg::OP_ERASE);
                    cnt_d = eep_pkg::CNT_W'(eep_pkg::SU_CYC - 1);
                    st_d = S_SETUP;
                end
            end
            S_SETUP:
            begin
                if (cnt_q == '0)
                begin
                    st_d = S_PULSE;
                    if (op_q == eep_pkg::OP_WRITE)
                    begin
                        // strobe wide enough to pass the glitch filter
                        we_d = 1'b0;
                        dq_oe_d = 1'b1;
                        cnt_d = eep_pkg::CNT_W'(eep_pkg::WP_CYC - 1);
                    end
                    else if (op_q == eep_pkg::OP_ERASE)
                    begin
                        we_d = 1'b0;
                        cnt_d = eep_pkg::CNT_W'(ERASE_CYC - 1);
                    end
                    else
                    begin
                        oe_d = 1'b0;
                        cnt_d = eep_pkg::CNT_W'(eep_pkg::ACC_CYC - 1);
                    end
                end
            end
            S_PULSE:
            begin
                if (cnt_q == '0)
                begin
                    if (op_q == eep_pkg::OP_READ || op_q == eep_pkg::OP_POLL)
                    begin
                        rd_d = i_dq;
                    end
                    // data stays driven past the rising strobe
                    we_d = 1'b1;
                    oe_d = 1'b1;
                    cnt_d = eep_pkg::CNT_W'(eep_pkg::HOLD_CYC - 1);
                    st_d = S_HOLD;
                end
            end
            S_HOLD:
            begin
                if (cnt_q == '0)
                begin
                    ce_d = 1'b1;
                    dq_oe_d = 1'b0;
                    hv_d = 1'b0;
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_q <= S_IDLE;
            cnt_q <= '0;
            op_q <= eep_pkg::OP_READ;
            addr_q <= '0;
            dq_q <= '0;
            rd_q <= '0;
            dq_oe_q <= 1'b0;
            ce_q <= 1'b1;
            oe_q <= 1'b1;
            we_q <= 1'b1;
            hv_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            addr_q <= addr_d;
            dq_q <= dq_d;
            rd_q <= rd_d;
            dq_oe_q <= dq_oe_d;
            ce_q <= ce_d;
            oe_q <= oe_d;
            we_q <= we_d;
            hv_q <= hv_d;
            done_q <= done_d;
        end
    end

    assign o_addr = addr_q;
    assign o_dq = dq_q;
    assign o_dq_oe = dq_oe_q;
    assign o_ce_n = ce_q;
    assign o_oe_n = oe_q;
    assign o_we_n = we_q;
    assign o_oe_hv = hv_q;
    assign sif.done = done_q;
    assign sif.rdata = rd_q;
endmodule
`default_nettype wire

// ===== src/eep_host.sv
// host controller for a 2K x 8 parallel eeprom, wishbone register port
// assumes the eeprom powers up with this block's reset release
//
// Notes on behaviour
// - host writes by holding we and ce low with oe high.
// - up to 64 bytes; next byte due within the page window.
// - all page bytes share page bits or the page is dropped.
// - enable key is three bytes to three addresses on three pages.
// - disable key is six bytes to six addresses in order.
// - chip erase: ce low, oe high voltage, 10 ms we pulse.
`timescale 1ns/1ns
`default_nettype none
module eep_host #(
    parameter int PUW_CYC = eep_pkg::PUW_MS * eep_pkg::MS_CYC,
    parameter int ERASE_CYC = eep_pkg::ERASE_MS * eep_pkg::MS_CYC,
    parameter int PAGE_WIN_CYC = eep_pkg::PAGE_WIN_US * 1000 / eep_pkg::CLK_NS
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic [10:0] o_addr,
    output logic [7:0] o_dq,
    output logic o_dq_oe,
    input wire logic [7:0] i_dq,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_oe_hv,
    input wire logic i_write_done_flag
);
    typedef enum {M_IDLE, M_RUN, M_POLL} eep_main_st_t;
    eep_main_st_t st_q, st_d;
    eep_seq_if sif ();
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [10:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d, rd_q, rd_d;
    eep_pkg::eep_op_t op_q, op_d;
    logic req_q, req_d;
    logic refused_q, refused_d, mix_q, mix_d;
    logic [4:0] page_q, page_d;
    logic [eep_pkg::CNT_W-1:0] win_q, win_d, pwr_q, pwr_d;
    logic tog_q, tog_d, have_q, have_d;
    logic wr_hit, rd_hit, write_ok, read_ok, launch;
    eep_pkg::eep_op_t new_op;
    logic [31:0] status;

    assign write_ok = (pwr_q >= eep_pkg::CNT_W'(PUW_CYC));
    assign read_ok = (pwr_q >= eep_pkg::CNT_W'(eep_pkg::PUR_CYC));
    assign wr_hit = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q;
    assign rd_hit = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q;
    assign new_op = eep_pkg::eep_op_t'(i_wb_dat[1:0]);
    assign launch = wr_hit && i_wb_adr == eep_pkg::REG_CTRL && i_wb_sel[0];

    always_comb
    begin
        status = '0;
        status[eep_pkg::ST_BUSY] = (st_q != M_IDLE);
        status[eep_pkg::ST_REFUSED] = refused_q;
        status[eep_pkg::ST_PAGE_MIX] = mix_q;
        status[eep_pkg::ST_WIN_OPEN] = (win_q != '0);
        status[eep_pkg::ST_WRITE_OK] = write_ok;
        status[eep_pkg::ST_READ_OK] = read_ok;
        status[eep_pkg::ST_READY] = i_write_done_flag;
        status[eep_pkg::ST_RDATA +: 8] = rd_q;
    end

    always_comb
    begin
        st_d = st_q;
        ack_d = i_wb_cyc && i_wb_stb && !ack_q;
        rdat_d = '0;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rd_d = rd_q;
        op_d = op_q;
        req_d = 1'b0;
        refused_d = refused_q;
        mix_d = mix_q;
        page_d = page_q;
        tog_d = tog_q;
        have_d = have_q;
        win_d = (win_q != '0) ? win_q - 1'b1 : win_q;
        pwr_d = write_ok ? pwr_q : pwr_q + 1'b1;
        if (rd_hit)
        begin
            unique case (i_wb_adr)
                eep_pkg::REG_ADDR: rdat_d = {21'h0, addr_q};
                eep_pkg::REG_WDATA: rdat_d = {24'h0, wdata_q};
                eep_pkg::REG_STATUS: rdat_d = status;
                eep_pkg::REG_CTRL: rdat_d = {30'h0, op_q};
                default: rdat_d = '0;
            endcase
        end
        if (wr_hit && i_wb_adr == eep_pkg::REG_ADDR)
        begin
            if (i_wb_sel[0])
            begin
                addr_d[7:0] = i_wb_dat[7:0];
            end
            if (i_wb_sel[1])
            begin
                addr_d[10:8] = i_wb_dat[10:8];
            end
        end
        if (wr_hit && i_wb_adr == eep_pkg::REG_WDATA && i_wb_sel[0])
        begin
            wdata_d = i_wb_dat[7:0];
        end
        // write-one clears; a set below in the same cycle wins
        if (wr_hit && i_wb_adr == eep_pkg::REG_STATUS && i_wb_sel[0])
        begin
            if (i_wb_dat[eep_pkg::ST_REFUSED])
            begin
                refused_d = 1'b0;
            end
            if (i_wb_dat[eep_pkg::ST_PAGE_MIX])
            begin
                mix_d = 1'b0;
            end
        end
        unique case (st_q)
            M_IDLE:
            begin
                if (launch)
                begin
                    if (new_op == eep_pkg::OP_WRITE
                        || new_op == eep_pkg::OP_ERASE)
                    begin
                        if (!write_ok)
                        begin
                            refused_d = 1'b1;
                        end
                        else
                        begin
                            op_d = new_op;
                            req_d = 1'b1;
                            st_d = M_RUN;
                            // key sequences cross pages on purpose, so a
                            // mixed page is only flagged, never blocked
                            if (new_op == eep_pkg::OP_WRITE && win_q != '0
                                && addr_q[10:eep_pkg::PAGE_LSB] != page_q)
                            begin
                                mix_d = 1'b1;
                            end
                        end
                    end
                    else if (!read_ok)
                    begin
                        refused_d = 1'b1;
                    end
                    else
                    begin
                        op_d = new_op;
                        req_d = 1'b1;
                        have_d = 1'b0;
                        st_d = (new_op == eep_pkg::OP_POLL) ? M_POLL : M_RUN;
                    end
                end
            end
            M_RUN:
            begin
                if (sif.done)
                begin
                    st_d = M_IDLE;
                    if (op_q == eep_pkg::OP_READ)
                    begin
                        rd_d = sif.rdata;
                    end
                    if (op_q == eep_pkg::OP_WRITE)
                    begin
                        // next byte of a page is due before this expires
                        win_d = eep_pkg::CNT_W'(PAGE_WIN_CYC);
                        page_d = addr_q[10:eep_pkg::PAGE_LSB];
                    end
                end
            end
            M_POLL:
            begin
                // two equal toggle reads in a row mean the write is over
                if (sif.done)
                begin
                    rd_d = sif.rdata;
                    if (have_q && sif.rdata[eep_pkg::TOGGLE_BIT] == tog_q)
                    begin
                        st_d = M_IDLE;
                    end
                    else
                    begin
                        tog_d = sif.rdata[eep_pkg::TOGGLE_BIT];
                        have_d = 1'b1;
                        req_d = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_q <= M_IDLE;
            ack_q <= 1'b0;
            rdat_q <= '0;
            addr_q <= '0;
            wdata_q <= '0;
            rd_q <= '0;
            op_q <= eep_pkg::OP_READ;
            req_q <= 1'b0;
            refused_q <= 1'b0;
            mix_q <= 1'b0;
            page_q <= '0;
            win_q <= '0;
            pwr_q <= '0;
            tog_q <= 1'b0;
            have_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rd_q <= rd_d;
            op_q <= op_d;
            req_q <= req_d;
            refused_q <= refused_d;
            mix_q <= mix_d;
            page_q <= page_d;
            win_q <= win_d;
            pwr_q <= pwr_d;
            tog_q <= tog_d;
            have_q <= have_d;
        end
    end

    assign sif.req = req_q;
    assign sif.op = op_q;
    assign sif.addr = addr_q;
    assign sif.wdata = wdata_q;
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    eep_pin_seq #(
        .ERASE_CYC(ERASE_CYC)
    ) u_seq (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .sif(sif),
        .o_addr(o_addr),
        .o_dq(o_dq),
        .o_dq_oe(o_dq_oe),
        .i_dq(i_dq),
        .o_ce_n(o_ce_n),
        .o_oe_n(o_oe_n),
        .o_we_n(o_we_n),
        .o_oe_hv(o_oe_hv)
    );
endmodule
`default_nettype wire

// ===== tb/eep_host_props.sv
// timing checker for the eeprom host controller
// sees only the ports of eep_host; bound at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module eep_host_props #(
    parameter int PUW_CYC = 200,
    parameter int ERASE_CYC = 50
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [10:0] o_addr,
    input wire logic [7:0] o_dq,
    input wire logic o_dq_oe,
    input wire logic o_ce_n,
    input wire logic o_oe_n,
    input wire logic o_we_n,
    input wire logic o_oe_hv
);
    // up_q saturates so it never wraps in long runs
    logic [20:0] up_q;
    logic [20:0] up_d;
    logic [20:0] low_q;
    logic [20:0] low_d;
    always_comb
    begin
        up_d = (up_q < 21'(PUW_CYC)) ? up_q + 21'h1 : up_q;
        low_d = o_we_n ? 21'h0 : low_q + 21'h1;
    end
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            up_q <= 21'h0;
            low_q <= 21'h0;
        end
        else
        begin
            up_q <= up_d;
            low_q <= low_d;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_ack_lat;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    property p_ack_pulse;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_dat_idle;
        !o_wb_ack |-> o_wb_dat == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
    property p_rd_pins;
        !o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe;
    endproperty
    a_rd_pins: assert property (p_rd_pins) else $error("bad read");
    property p_wr_pins;
        !o_we_n |-> !o_ce_n && o_oe_n;
    endproperty
    a_wr_pins: assert property (p_wr_pins) else $error("bad write");
    property p_drv;
        o_dq_oe |-> o_oe_n && !o_ce_n;
    endproperty
    a_drv: assert property (p_drv) else $error("bus clash");
    property p_addr;
        !o_ce_n && $past(!o_ce_n) |-> $stable(o_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("addr moved");
    property p_data;
        !o_we_n && !o_oe_hv |=> $stable(o_dq);
    endproperty
    a_data: assert property (p_data) else $error("data moved");
    property p_wpulse;
        $rose(o_we_n) && !o_oe_hv |-> low_q == 21'(eep_pkg::WP_CYC);
    endproperty
    a_wpulse: assert property (p_wpulse) else $error("we width");
    property p_erase;
        $rose(o_we_n) && o_oe_hv |-> low_q == 21'(ERASE_CYC);
    endproperty
    a_erase: assert property (p_erase) else $error("erase width");
    property p_puw;
        up_q < 21'(PUW_CYC) |-> o_we_n;
    endproperty
    a_puw: assert property (p_puw) else $error("early write");
    property p_pur;
        up_q < 21'(eep_pkg::PUR_CYC) |-> o_oe_n;
    endproperty
    a_pur: assert property (p_pur) else $error("early read");
endmodule
bind eep_host eep_host_props #(.PUW_CYC(PUW_CYC), .ERASE_CYC(ERASE_CYC))
    u_props (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_oe_hv(o_oe_hv));
`default_nettype wire

// ===== tb/eep_mem_model.sv
// behavioural 2K x 8 eeprom with page timer and status bits
// assumes strobes change only on i_clk edges; i_rst stands for power-up
`timescale 1ns/1ns
`default_nettype none
module eep_mem_model #(
    parameter int WIN_CYC = 100,
    parameter int WR_CYC = 200,
    parameter int PUW_CYC = 200,
    parameter int ERASE_CYC = 50,
    // key words are {address, data}; values arbitrary
    parameter logic [2:0][18:0] KEY_ON = {19'h2aaa0, 19'h155c3, 19'h0aa3c},
    parameter logic [5:0][18:0] KEY_OFF = {19'h55520, 19'h4aac3,
        19'h3553c, 19'h2aa80, 19'h155c3, 19'h0aa3c}
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [10:0] i_addr,
    input wire logic [7:0] i_dq,
    input wire logic i_dq_oe,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_oe_hv,
    output logic [7:0] o_bus,
    output logic o_rdy
);
    logic [7:0] mem [2048];
    logic [7:0] pbuf [64];
    logic [63:0] pv = 64'h0;
    logic [10:0] a_q = 11'h0;
    logic [4:0] pg = 5'h0;
    logic [7:0] last = 8'h0;
    logic [7:0] rd;
    logic mix = 1'b0;
    logic tog = 1'b0;
    logic flt = 1'b0;
    logic we_p = 1'b1;
    logic oe_p = 1'b1;
    logic lock = 1'b0;
    logic [1:0] kon = 2'h0;
    logic [2:0] koff = 3'h0;
    int win = 0;
    int busy = 0;
    int up = 0;
    int low = 0;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hff;
    end
    assign rd = busy > 0 ? {~last[7], tog, 1'b1, 5'h0} : mem[i_addr];
    // released bus flips every cycle so stale data never reads as valid
    assign o_bus = i_dq_oe ? i_dq : (!i_ce_n && !i_oe_n && i_we_n &&
        up >= eep_pkg::PUR_CYC) ? rd : {8{flt}};
    assign o_rdy = busy == 0;
    always @(posedge i_clk)
    begin
        flt <= ~flt;
        we_p <= i_we_n;
        oe_p <= i_oe_n;
        low <= i_we_n ? 0 : low + 1;
        up <= i_rst ? 0 : up + 1;
        if (win > 0)
            win <= win - 1;
        if (busy > 0)
            busy <= busy - 1;
        if (busy > 0 && i_oe_n && !oe_p)
            tog <= ~tog;
        if (!i_we_n && we_p && !i_ce_n)
            a_q <= i_addr;
        if (win == 1)
        begin
            busy <= WR_CYC;
            tog <= 1'b0;
            for (int j = 0; j < 64; j++)
                if (pv[j] && !mix)
                    mem[{pg, 6'(j)}] <= pbuf[j];
        end
        // a one-cycle strobe pulse is a glitch and latches nothing
        if (i_we_n && !we_p && !i_ce_n && low > 1)
        begin
            if (!i_oe_hv)
            begin
                kon <= {a_q, i_dq} == KEY_ON[kon] && kon != 2'h2 ?
                    kon + 2'h1 : 2'h0;
                koff <= {a_q, i_dq} == KEY_OFF[koff] && koff != 3'h5 ?
                    koff + 3'h1 : 3'h0;
            end
            if (!i_oe_hv && kon == 2'h2 && {a_q, i_dq} == KEY_ON[2])
                lock <= 1'b1;
            if (!i_oe_hv && koff == 3'h5 && {a_q, i_dq} == KEY_OFF[5])
                lock <= 1'b0;
            if (!lock && busy == 0 && up >= PUW_CYC)
            begin
                if (i_oe_hv && low >= ERASE_CYC)
                    foreach (mem[i]) mem[i] <= 8'hff;
                else if (!i_oe_hv)
                begin
                    pbuf[a_q[5:0]] <= i_dq;
                    pv <= (win == 0 ? 64'h0 : pv) | (64'h1 << a_q[5:0]);
                    pg <= win == 0 ? a_q[10:6] : pg;
                    mix <= win != 0 && (mix || a_q[10:6] != pg);
                    last <= i_dq;
                    win <= WIN_CYC;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/eep_host_tb_top.sv
// self-checking bench: wishbone tasks drive eep_host and a model eeprom
// assumes shortened holdoff, erase and window counts set below
`timescale 1ns/1ns
`default_nettype none
module eep_host_tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack, dq_oe, ce_n, oe_n, we_n, oe_hv, rdy;
    logic [10:0] addr;
    logic [7:0] dq_o;
    logic [7:0] bus;
    int err_count = 0;
    int comparisons = 0;
    always #4 i_clk = ~i_clk;
    eep_host #(.PUW_CYC(200), .ERASE_CYC(50), .PAGE_WIN_CYC(100)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_addr(addr), .o_dq(dq_o),
        .o_dq_oe(dq_oe), .i_dq(bus), .o_ce_n(ce_n), .o_oe_n(oe_n),
        .o_we_n(we_n), .o_oe_hv(oe_hv), .i_write_done_flag(rdy));
    // model defaults already equal the shortened counts of u_dut
    eep_mem_model u_mem (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_dq(dq_o),
        .i_dq_oe(dq_oe), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_oe_hv(oe_hv), .o_bus(bus), .o_rdy(rdy));
    task automatic results;
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tmo;
        err_count++;
        $display("[ERR] %0t wait timed out", $time);
        results();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1)
            tmo();
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, eep_pkg::REG_STATUS, 32'h0);
            n++;
        end
        while (q[b] !== v && n < 1000);
        if (q[b] !== v)
            tmo();
    endtask
    task automatic run(input logic [1:0] op);
        wb(1'b1, eep_pkg::REG_CTRL, {30'h0, op});
        wait_bit(eep_pkg::ST_BUSY, 1'b0);
    endtask
    task automatic rd_byte(input logic [10:0] a, input logic [7:0] e);
        wb(1'b1, eep_pkg::REG_ADDR, {21'h0, a});
        run(eep_pkg::OP_READ);
        chk({24'h0, q[15:8]}, {24'h0, e});
    endtask
    task automatic wr_byte(input logic [10:0] a, input logic [7:0] d);
        wb(1'b1, eep_pkg::REG_ADDR, {21'h0, a});
        wb(1'b1, eep_pkg::REG_WDATA, {24'h0, d});
        run(eep_pkg::OP_WRITE);
    endtask
    task automatic settle;
        wait_bit(eep_pkg::ST_WIN_OPEN, 1'b0);
        run(eep_pkg::OP_POLL);
    endtask
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        wb(1'b0, eep_pkg::REG_STATUS, 32'h0);
        chk({29'h0, q[5:4], q[0]}, 32'h0);
        sel <= 4'h1;
        wb(1'b1, eep_pkg::REG_ADDR, 32'h7ff);
        sel <= 4'hf;
        wb(1'b0, eep_pkg::REG_ADDR, 32'h0);
        chk(q, 32'h0ff);
        wb(1'b0, 8'h10, 32'hffffffff);
        chk(q, 32'h0);
        wb(1'b1, eep_pkg::REG_CTRL, {30'h0, eep_pkg::OP_WRITE});
        wb(1'b0, eep_pkg::REG_STATUS, 32'h0);
        chk({31'h0, q[1]}, 32'h1);
        wb(1'b1, eep_pkg::REG_STATUS, 32'h2);
        wait_bit(eep_pkg::ST_WRITE_OK, 1'b1);
        chk({29'h0, q[2:0]}, 32'h0);
        rd_byte(11'h7ff, 8'hff);
        wr_byte(11'h123, 8'ha5);
        wb(1'b0, eep_pkg::REG_STATUS, 32'h0);
        chk({31'h0, q[3]}, 32'h1);
        wait_bit(eep_pkg::ST_WIN_OPEN, 1'b0);
        wb(1'b0, eep_pkg::REG_STATUS, 32'h0);
        chk({31'h0, q[6]}, 32'h0);
        run(eep_pkg::OP_POLL);
        chk({24'h0, q[15:8]}, 32'ha5);
        chk({31'h0, q[6]}, 32'h1);
        rd_byte(11'h123, 8'ha5);
        for (int k = 0; k < 4; k++)
            wr_byte(11'h140 + 11'(k * 21), 8'h30 + 8'(k));
        settle();
        for (int k = 0; k < 4; k++)
            rd_byte(11'h140 + 11'(k * 21), 8'h30 + 8'(k));
        wr_byte(11'h200, 8'h11);
        wr_byte(11'h7c0, 8'h22);
        wb(1'b0, eep_pkg::REG_STATUS, 32'h0);
        chk({31'h0, q[2]}, 32'h1);
        settle();
        rd_byte(11'h200, 8'hff);
        rd_byte(11'h7c0, 8'hff);
        wb(1'b1, eep_pkg::REG_STATUS, 32'h4);
        wb(1'b0, eep_pkg::REG_STATUS, 32'h0);
        chk({31'h0, q[2]}, 32'h0);
        for (int k = 0; k < 3; k++)
            wr_byte(u_mem.KEY_ON[k][18:8], u_mem.KEY_ON[k][7:0]);
        settle();
        wr_byte(11'h300, 8'h77);
        settle();
        rd_byte(11'h300, 8'hff);
        for (int k = 0; k < 6; k++)
            wr_byte(u_mem.KEY_OFF[k][18:8], u_mem.KEY_OFF[k][7:0]);
        settle();
        wr_byte(11'h300, 8'h77);
        settle();
        rd_byte(11'h300, 8'h77);
        run(eep_pkg::OP_ERASE);
        rd_byte(11'h123, 8'hff);
        rd_byte(11'h17f, 8'hff);
        results();
    end
endmodule
`default_nettype wire
